// ===== rtl/lsb_top.sv
/*
  LIN setup front end: direct mode register, indirect index/data access,
  manual bit-rate generator, checksum unit and frame start/flag handling.
  Assumes the frame engine outside reports completion and errors as
  one-cycle pulses, and all inputs are synchronous to CLK_SYS_IN.
*/
`timescale 1ns/100ps
`default_nettype none
module lsb_top #(
  parameter int DIV_W = 9
) (
  // Clock and control
  input  wire logic               CLK_SYS_IN,
  input  wire logic               RST_N_IN,
  input  wire logic               CE_IN,
  // CPU register port
  input  wire lsb_pkg::lsb_req_type REQ_IN,
  output var  logic [7:0]         RDATA_OUT,
  // Frame engine events
  input  wire logic               FRAME_DONE_IN,
  input  wire logic               FRAME_ERROR_IN,
  // Checksum byte stream
  input  wire lsb_pkg::lsb_cs_type CS_IN,
  // Status and control outputs
  output var  logic               ACTIVE_OUT,
  output var  logic               MASTER_OUT,
  output var  logic               AUTOBAUD_OUT,
  output var  logic               START_OUT,
  output var  logic               BIT_STROBE_OUT,
  output var  logic               IRQ_OUT,
  output var  logic               ERROR_OUT,
  output var  logic [7:0]         CHECKSUM_OUT,
  output var  logic               CS_OK_OUT,
  output var  logic               CS_CHECKED_OUT
);
  import lsb_pkg::*;

  // Elaboration-time refusal: the divider field and range logic are nine bits wide
  if (DIV_W != 9) begin
    $error("lsb_top: divider field must be nine bits");
  end

  typedef struct packed {
    logic [7:0]       mode;
    logic [7:0]       index;
    logic [7:0]       ctrl;
    logic [7:0]       size;
    logic [7:0]       divlo;
    logic [7:0]       presmul;
    logic             busy;
    logic             done;
    logic             err;
    logic             irq;
    logic             start;
    logic [7:0]       rdata;
    logic [3:0]       pre_cnt;
    logic [DIV_W-1:0] div_cnt;
    logic [4:0]       mul_cnt;
    logic             strobe;
    logic [7:0]       cs_sum;
    logic [7:0]       cs_out;
    logic             cs_ok;
    logic             cs_chk;
  } lsb_state_type;

  lsb_state_type st_reg;
  lsb_state_type st_next;

  function automatic logic [7:0] add_carry(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[7:0] + {7'h00, s[8]};
  endfunction

  logic             is_master;
  logic             is_active;
  logic [1:0]       pre;
  logic [4:0]       mul_last;
  logic [3:0]       pre_last;
  logic [DIV_W-1:0] div_raw;
  logic [DIV_W-1:0] div_last;
  logic             wr_data;
  logic             wr_ctrl;
  logic [7:0]       cs_seed;
  logic [7:0]       cs_acc;
  logic [7:0]       idx_rd;
  logic [7:0]       status;

  always_comb begin
    is_master = st_reg.mode[MODE_MASTER_BIT];
    is_active = st_reg.mode[MODE_ACTIVE_BIT];
    pre       = st_reg.presmul[PRE_MSB:PRE_LSB];
    // Slave autobaud works from prescaler and divider only
    mul_last  = st_reg.mode[MODE_AUTOBAUD_SELECT_BIT] ? 5'h00 : st_reg.presmul[MUL_MSB:MUL_LSB];
    pre_last  = 4'((5'h02 << pre) - 5'h01);
    div_raw   = {st_reg.presmul[DIV8_BIT], st_reg.divlo};
    // Out-of-range divider is lifted to the floor instead of running too fast
    div_last  = ((div_raw < DIV_MIN) ? DIV_MIN : div_raw) - 9'h001;
    wr_data   = REQ_IN.wr && (REQ_IN.sel == SEL_DATA);
    wr_ctrl   = wr_data && (st_reg.index == IDX_CONTROL);
    cs_seed   = st_reg.size[SIZE_ENH_BIT] ? CS_IN.pid : 8'h00;
    cs_acc    = add_carry(CS_IN.clear ? cs_seed : st_reg.cs_sum, CS_IN.data);
    status    = 8'h00;
    status[STAT_DONE_BIT] = st_reg.done;
    status[STAT_BUSY_BIT] = st_reg.busy;
    status[STAT_ERR_BIT]  = st_reg.err;
    status[STAT_IRQ_BIT]  = st_reg.irq;
    unique case (st_reg.index)
      IDX_CONTROL: idx_rd = (st_reg.ctrl & CTRL_KEEP_MASK) | {7'h00, st_reg.busy};
      IDX_STATUS:  idx_rd = status;
      IDX_SIZE:    idx_rd = st_reg.size;
      IDX_DIVLO:   idx_rd = st_reg.divlo;
      IDX_PRESMUL: idx_rd = st_reg.presmul;
      default:     idx_rd = 8'h00;
    endcase
  end

  always_comb begin
    st_next       = st_reg;
    st_next.start = 1'b0;

    // Direct registers
    if (REQ_IN.wr && REQ_IN.sel == SEL_MODE) begin
      st_next.mode = REQ_IN.wdata;
      // A master never runs on derived timing
      if (REQ_IN.wdata[MODE_MASTER_BIT]) begin
        st_next.mode[MODE_AUTOBAUD_SELECT_BIT] = 1'b0;
      end
    end
    if (REQ_IN.wr && REQ_IN.sel == SEL_INDEX) begin
      st_next.index = REQ_IN.wdata;
    end

    // Indirect registers
    if (wr_data) begin
      unique case (st_reg.index)
        IDX_CONTROL: st_next.ctrl    = REQ_IN.wdata & CTRL_KEEP_MASK;
        IDX_SIZE:    st_next.size    = REQ_IN.wdata;
        IDX_DIVLO:   st_next.divlo   = REQ_IN.wdata;
        IDX_PRESMUL: st_next.presmul = REQ_IN.wdata;
        default:     st_next.ctrl    = st_reg.ctrl;
      endcase
    end

    // Flag clears first so that a same-cycle event wins
    if (wr_ctrl && REQ_IN.wdata[CTRL_RSTERR_BIT]) begin
      st_next.err  = 1'b0;
      st_next.done = 1'b0;
    end
    if (wr_ctrl && REQ_IN.wdata[CTRL_RSTINT_BIT]) begin
      st_next.irq = 1'b0;
    end

    // Frame start and completion
    if (wr_ctrl && REQ_IN.wdata[CTRL_START_BIT] && is_active && is_master && !st_reg.busy) begin
      st_next.busy  = 1'b1;
      st_next.start = 1'b1;
      st_next.done  = 1'b0;
    end
    if (st_reg.busy && (FRAME_DONE_IN || FRAME_ERROR_IN)) begin
      st_next.busy = 1'b0;
      st_next.irq  = 1'b1;
      if (FRAME_DONE_IN) begin
        st_next.done = 1'b1;
      end
      if (FRAME_ERROR_IN) begin
        st_next.err = 1'b1;
      end
    end

    // Registered read data
    if (REQ_IN.rd) begin
      unique case (REQ_IN.sel)
        SEL_MODE:  st_next.rdata = st_reg.mode;
        SEL_INDEX: st_next.rdata = st_reg.index;
        SEL_DATA:  st_next.rdata = idx_rd;
        default:   st_next.rdata = 8'h00;
      endcase
    end

    // Bit-time generator, idle and reloaded while inactive
    st_next.strobe = 1'b0;
    if (!is_active) begin
      st_next.pre_cnt = 4'h0;
      st_next.div_cnt = '0;
      st_next.mul_cnt = 5'h00;
      st_next.busy    = 1'b0;
    end else if (st_reg.pre_cnt < pre_last) begin
      st_next.pre_cnt = st_reg.pre_cnt + 4'h1;
    end else begin
      st_next.pre_cnt = 4'h0;
      if (st_reg.div_cnt < div_last) begin
        st_next.div_cnt = st_reg.div_cnt + 9'h001;
      end else begin
        st_next.div_cnt = '0;
        if (st_reg.mul_cnt < mul_last) begin
          st_next.mul_cnt = st_reg.mul_cnt + 5'h01;
        end else begin
          // New bit period: every stage restarts from zero and counts up to one below its division factor
          st_next.mul_cnt = 5'h00;
          st_next.strobe  = 1'b1;
        end
      end
    end

    // Checksum accumulation and check
    st_next.cs_chk = 1'b0;
    if (CS_IN.clear && !CS_IN.valid) begin
      st_next.cs_sum = cs_seed;
    end else if (CS_IN.valid && CS_IN.last) begin
      // Sum plus received checksum must reach all ones
      st_next.cs_ok  = (cs_acc == 8'hff);
      st_next.cs_chk = 1'b1;
    end else if (CS_IN.valid) begin
      st_next.cs_sum = cs_acc;
    end
    st_next.cs_out = ~st_next.cs_sum;
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      st_reg       <= '0;
      st_reg.mode  <= REG_RESET;
      st_reg.size  <= REG_RESET;
      st_reg.divlo <= REG_RESET;
      st_reg.cs_out <= 8'hff;
    end else if (CE_IN) begin
      st_reg <= st_next;
    end
  end

  always_comb begin
    RDATA_OUT      = st_reg.rdata;
    ACTIVE_OUT     = st_reg.mode[MODE_ACTIVE_BIT];
    MASTER_OUT     = st_reg.mode[MODE_MASTER_BIT];
    AUTOBAUD_OUT   = st_reg.mode[MODE_AUTOBAUD_SELECT_BIT];
    START_OUT      = st_reg.start;
    BIT_STROBE_OUT = st_reg.strobe;
    IRQ_OUT        = st_reg.irq;
    ERROR_OUT      = st_reg.err;
    CHECKSUM_OUT   = st_reg.cs_out;
    CS_OK_OUT      = st_reg.cs_ok;
    CS_CHECKED_OUT = st_reg.cs_chk;
  end
endmodule
`default_nettype wire

// ===== pkg/lsb_pkg.sv
/*
  Constants and carriers for the LIN setup and bit-rate block.
  Assumes a CPU-side register port of three directly addressed byte registers.
*/
package lsb_pkg;
  // Direct register selects
  localparam logic [1:0] SEL_MODE  = 2'h0;
  localparam logic [1:0] SEL_INDEX = 2'h1;
  localparam logic [1:0] SEL_DATA  = 2'h2;

  // Indirect register indices
  localparam logic [7:0] IDX_CONTROL = 8'h08;
  localparam logic [7:0] IDX_STATUS  = 8'h09;
  localparam logic [7:0] IDX_SIZE    = 8'h0b;
  localparam logic [7:0] IDX_DIVLO   = 8'h0c;
  localparam logic [7:0] IDX_PRESMUL = 8'h0d;

  // Mode register fields
  localparam int MODE_ACTIVE_BIT = 7;
  localparam int MODE_MASTER_BIT = 6;
  localparam int MODE_AUTOBAUD_SELECT_BIT  = 5;

  // Control register fields
  localparam int CTRL_START_BIT  = 0;
  localparam int CTRL_RSTERR_BIT = 2;
  localparam int CTRL_RSTINT_BIT = 3;
  localparam logic [7:0] CTRL_KEEP_MASK = 8'hf0;

  // Status register fields
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_ERR_BIT  = 2;
  localparam int STAT_IRQ_BIT  = 3;

  // Size register checksum type
  localparam int SIZE_ENH_BIT = 7;

  // Prescale/multiply field layout
  localparam int PRE_MSB = 7;
  localparam int PRE_LSB = 6;
  localparam int MUL_MSB = 5;
  localparam int MUL_LSB = 1;
  localparam int DIV8_BIT = 0;

  // Divider range
  localparam logic [8:0] DIV_MIN = 9'h0c8;

  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] sel;
    logic [7:0] wdata;
  } lsb_req_type;

  typedef struct packed {
    logic       clear;
    logic       valid;
    logic       last;
    logic [7:0] pid;
    logic [7:0] data;
  } lsb_cs_type;
endpackage

// ===== test/lsb_monitor.sv
/* Port checker for lsb_top.
   Assumes CE_IN is held high and the checker is bound to every lsb_top. */
`timescale 1ns/100ps
`default_nettype none
module lsb_monitor
  import lsb_pkg::*;
(
  // Clock and control
  input wire logic        CLK_SYS_IN,
  input wire logic        RST_N_IN,
  // Inputs seen
  input wire lsb_req_type REQ_IN,
  input wire logic        FRAME_DONE_IN,
  input wire logic        FRAME_ERROR_IN,
  // Outputs seen
  input wire logic        ACTIVE_OUT,
  input wire logic        MASTER_OUT,
  input wire logic        AUTOBAUD_OUT,
  input wire logic        START_OUT,
  input wire logic        BIT_STROBE_OUT,
  input wire logic        IRQ_OUT,
  input wire logic        ERROR_OUT
);
  logic [7:0] idx_reg;
  wire logic  mw = REQ_IN.wr && REQ_IN.sel == SEL_MODE;
  wire logic  cw = REQ_IN.wr && REQ_IN.sel == SEL_DATA && idx_reg == IDX_CONTROL;
  // Shadow of the index so control writes can be recognised
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN)
      idx_reg <= 8'h00;
    else if (REQ_IN.wr && REQ_IN.sel == SEL_INDEX)
      idx_reg <= REQ_IN.wdata;
  end
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);
  property p_master; mw |=> MASTER_OUT == $past(REQ_IN.wdata[6]); endproperty
  a_master: assert property (p_master) else $error("master bit mismatch");
  property p_autobaud_select; mw |=> AUTOBAUD_OUT == $past(REQ_IN.wdata[5] & ~REQ_IN.wdata[6]); endproperty
  a_autobaud_select: assert property (p_autobaud_select) else $error("autobaud bit mismatch");
  property p_active; mw |=> ACTIVE_OUT == $past(REQ_IN.wdata[7]); endproperty
  a_active: assert property (p_active) else $error("active bit mismatch");
  property p_start; START_OUT |-> $past(ACTIVE_OUT && MASTER_OUT); endproperty
  a_start: assert property (p_start) else $error("start while not master");
  property p_irq; $rose(IRQ_OUT) |-> $past(FRAME_DONE_IN || FRAME_ERROR_IN); endproperty
  a_irq: assert property (p_irq) else $error("interrupt without event");
  property p_err; $rose(ERROR_OUT) |-> $past(FRAME_ERROR_IN); endproperty
  a_err: assert property (p_err) else $error("error flag without event");
  property p_clear;
    cw && REQ_IN.wdata == 8'h0c && !FRAME_DONE_IN && !FRAME_ERROR_IN |=> !IRQ_OUT && !ERROR_OUT;
  endproperty
  a_clear: assert property (p_clear) else $error("flags not cleared");
  property p_idle; !ACTIVE_OUT && !$past(ACTIVE_OUT) |-> !BIT_STROBE_OUT; endproperty
  a_idle: assert property (p_idle) else $error("strobe while inactive");
  // Shortest legal bit period is far above eight cycles
  property p_gap; BIT_STROBE_OUT |=> !BIT_STROBE_OUT [*8]; endproperty
  a_gap: assert property (p_gap) else $error("strobes too close");
endmodule
bind lsb_top lsb_monitor mon_u (.CLK_SYS_IN, .RST_N_IN, .REQ_IN, .FRAME_DONE_IN, .FRAME_ERROR_IN,
  .ACTIVE_OUT, .MASTER_OUT, .AUTOBAUD_OUT, .START_OUT, .BIT_STROBE_OUT, .IRQ_OUT, .ERROR_OUT);
`default_nettype wire

// ===== test/lsb_engine_model.sv
/* Frame engine stand-in: answers a frame start with one done or error pulse.
   Assumes start arrives as a one-cycle pulse on the system clock. */
`timescale 1ns/100ps
`default_nettype none
module lsb_engine_model (
  // Clock and control
  input  wire logic clk_in,
  input  wire logic start_in,
  input  wire logic fail_in,
  // Events
  output var  logic done_out = 1'b0,
  output var  logic error_out = 1'b0
);
  logic [3:0] cnt_reg = 4'h0;
  // Fixed latency; a slow frame only stretches the wait
  always @(posedge clk_in) begin
    done_out  <= !start_in && cnt_reg == 4'h1 && !fail_in;
    error_out <= !start_in && cnt_reg == 4'h1 && fail_in;
    if (start_in)
      cnt_reg <= 4'h5;
    else if (cnt_reg != 4'h0)
      cnt_reg <= cnt_reg - 4'h1;
  end
endmodule
`default_nettype wire

// ===== test/tb_top.sv
/* Self-checking bench for lsb_top through its register port.
   Assumes the checker binds itself and the frame engine model answers starts. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import lsb_pkg::*;
  logic        clk = 0, rst_n = 0, fail = 0, act, mst, abd, start, stb, irq, err, ok, done, ferr;
  logic        chkd;
  lsb_req_type req = '0;
  lsb_cs_type  cs = '0;
  logic [7:0]  rdata, cks;
  logic [7:0]  md[5] = '{8'h40, 8'h60, 8'ha0, 8'h80, 8'hc0};
  // Firmware factors, truncated: pre1 mul0 div200, pre0 mul1 div256
  logic [7:0]  pm[2] = '{8'h40, 8'h03}, dl[2] = '{8'hc8, 8'h00};
  logic [15:0] per[2] = '{16'd800, 16'd1024}, p;
  int          num_errors = 0, n_compared = 0, n;
  always #2 clk = ~clk;
  lsb_top dut_u (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .CE_IN(1'b1), .REQ_IN(req),
    .RDATA_OUT(rdata), .FRAME_DONE_IN(done), .FRAME_ERROR_IN(ferr), .CS_IN(cs),
    .ACTIVE_OUT(act), .MASTER_OUT(mst), .AUTOBAUD_OUT(abd), .START_OUT(start),
    .BIT_STROBE_OUT(stb), .IRQ_OUT(irq), .ERROR_OUT(err), .CHECKSUM_OUT(cks),
    .CS_OK_OUT(ok), .CS_CHECKED_OUT(chkd));
  lsb_engine_model eng_u (.clk_in(clk), .start_in(start), .fail_in(fail), .done_out(done),
    .error_out(ferr));
  task automatic end_sim;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // A gap cycle between strobes keeps each raise apart from the last release
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    @(negedge clk) req = '{1'b1, 1'b0, s, d};
    @(negedge clk) req = '0;
  endtask
  task automatic wi(input logic [7:0] i, input logic [7:0] d);
    wr(SEL_INDEX, i);
    wr(SEL_DATA, d);
  endtask
  task automatic rchk(input logic [1:0] s, input logic [7:0] exp);
    @(negedge clk) req = '{1'b0, 1'b1, s, 8'h00};
    @(negedge clk) req = '0;
    chk(rdata, exp);
  endtask
  task automatic csput(input logic c, input logic l, input logic [7:0] d);
    @(negedge clk) cs = '{c, 1'b1, l, 8'h55, d};
    @(negedge clk) cs = '0;
  endtask
  task automatic period;
    p = 0;
    do begin
      @(negedge clk);
      p++;
    end while (stb !== 1'b1 && p < 3000);
    if (stb !== 1'b1) begin
      num_errors++;
      end_sim();
    end
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1;
    chk({act, mst, abd, start, irq, err, cks}, 16'h00ff);
    foreach (md[i]) begin
      wr(SEL_MODE, md[i]);
      chk({act, mst, abd}, {md[i][7], md[i][6], md[i][5] & ~md[i][6]});
    end
    wr(SEL_MODE, 8'h80);
    wi(IDX_CONTROL, 8'h01);
    chk(start, 0);
    wr(SEL_MODE, 8'hc0);
    rchk(2'h3, 8'h00);
    wr(SEL_INDEX, 8'h3f);
    rchk(SEL_DATA, 8'h00);
    for (int i = 0; i < 2; i++) begin
      wi(IDX_PRESMUL, pm[i]);
      wi(IDX_DIVLO, dl[i]);
      rchk(SEL_DATA, dl[i]);
      wr(SEL_INDEX, IDX_PRESMUL);
      rchk(SEL_DATA, pm[i]);
      repeat (3) period();
      chk(p, per[i]);
      wi(IDX_SIZE, {i[0], 7'h00});
      rchk(SEL_DATA, {i[0], 7'h00});
      csput(1'b1, 1'b0, 8'h01);
      chk(cks, i ? 8'ha9 : 8'hfe);
      csput(1'b0, 1'b1, i ? 8'ha9 : 8'hfe);
      chk({chkd, ok}, 2'b11);
      // A wrong received checksum must be flagged
      csput(1'b0, 1'b1, 8'h00);
      chk({chkd, ok}, 2'b10);
      fail = i[0];
      wi(IDX_CONTROL, 8'h01);
      chk(start, 1);
      n = 0;
      while (irq !== 1'b1 && n < 50) begin
        @(negedge clk);
        n++;
      end
      chk({irq, err}, {1'b1, fail});
      if (irq !== 1'b1) begin
        end_sim();
      end
      wr(SEL_INDEX, IDX_STATUS);
      rchk(SEL_DATA, i ? 8'h0c : 8'h09);
      wi(IDX_CONTROL, 8'h0c);
      chk({irq, err}, 0);
    end
    // Slave on derived timing ignores the multiplier: 2 x 256 x 1 cycles
    wr(SEL_MODE, 8'ha0);
    repeat (3) period();
    chk(p, 16'd512);
    end_sim();
  end
endmodule
`default_nettype wire
